// [hw/dcu_pkg.sv]
// Constants for the DMA channel address and byte-count update block.
// Assumes an Avalon-MM register slave and one external bus request port.
package dcu_pkg;

	// Register byte offsets
	localparam logic [4:0] OFS_SRC   = 5'h00;
	localparam logic [4:0] OFS_DST   = 5'h04;
	localparam logic [4:0] OFS_CNT   = 5'h08;
	localparam logic [4:0] OFS_OFFS  = 5'h0c;
	localparam logic [4:0] OFS_ACTL  = 5'h10;
	localparam logic [4:0] OFS_MODE  = 5'h14;
	localparam logic [4:0] OFS_BLK   = 5'h18;

	// address_control fields
	localparam int ACTL_SSTEP_LSB = 0;
	localparam int ACTL_DSTEP_LSB = 2;
	localparam int ACTL_SAREA     = 4;
	localparam int ACTL_DAREA     = 5;
	localparam int ACTL_REPEAT_END_IRQ_ENABLE     = 6;
	localparam int ACTL_SEXT_LSB  = 8;
	localparam int ACTL_DEXT_LSB  = 16;
	localparam logic [31:0] ACTL_MASK = 32'h001f1f7f;

	// channel_mode_control fields
	localparam int MODE_DTE      = 0;
	localparam int MODE_ACT      = 1;
	localparam int MODE_SIZE_LSB = 2;
	localparam int MODE_RPT      = 4;
	localparam int MODE_ERR      = 5;
	localparam int MODE_ESC      = 6;
	localparam int MODE_CEND     = 7;

	// Step modes and access sizes
	localparam logic [1:0] STEP_FIXED  = 2'h0;
	localparam logic [1:0] STEP_OFFSET = 2'h1;
	localparam logic [1:0] STEP_INC    = 2'h2;
	localparam logic [1:0] STEP_DEC    = 2'h3;
	localparam logic [1:0] SIZE_BYTE   = 2'h0;
	localparam logic [1:0] SIZE_WORD   = 2'h1;
	localparam logic [1:0] SIZE_LONG   = 2'h2;

	// Reset values
	localparam logic [31:0] RST_WORD = 32'h0;
	localparam logic [15:0] RST_HALF = 16'h0;

	typedef enum logic [1:0] {
		DCU_IDLE  = 2'b00,
		DCU_READ  = 2'b01,
		DCU_WRITE = 2'b10
	} dcu_state_t;

endpackage : dcu_pkg

// [hw/dcu_channel.sv]
// One DMA channel: register file, address/count update, split accesses.
// Assumes a bus controller that answers each request with bus_ack.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module dcu_channel (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        xfer_req,
	input  wire logic        halt_error,
	input  wire logic        standby,
	output logic             bus_req,
	output logic             bus_write,
	output logic      [31:0] bus_addr,
	output logic      [1:0]  bus_size,
	output logic      [31:0] bus_wdata,
	input  wire logic [31:0] bus_rdata,
	input  wire logic        bus_ack,
	output logic             unit_done
);

	dcu_pkg::dcu_state_t st_reg, st_next;
	logic [31:0] src_reg, dst_reg, cnt_reg, ofs_reg, actl_reg;
	logic [31:0] src_next, dst_next, cnt_next, actl_next, ofs_next;
	logic [31:0] src_start_reg, dst_start_reg, src_unit_reg, dst_unit_reg;
	logic [31:0] data_reg, data_next, rd_mux, wdata_reg;
	logic [15:0] bk_hi_reg, bk_lo_reg, bk_hi_next, bk_lo_next;
	logic [1:0]  size_reg;
	logic        dte_reg, rpt_reg, err_reg, esc_reg, cend_reg;
	logic [2:0]  done_reg, done_next;
	logic        waitreq_reg;
	logic [31:0] rdata_reg;
	logic        breq_reg, breq_next, bwr_reg, bwr_next;
	logic [31:0] baddr_reg, baddr_next;
	logic [1:0]  bsize_reg, bsize_next;
	logic        unit_done_reg;
	logic [31:0] src_hw, dst_hw;
	logic        src_hw_upd, dst_hw_upd;

	function automatic logic [31:0] area_mask(input logic [4:0] n);
		return (n == 5'h0) ? 32'hffffffff : ((32'h1 << n) - 32'h1);
	endfunction : area_mask

	function automatic logic [31:0] step_addr(input logic [1:0] mode,
		input logic [31:0] a, input logic [2:0] nb,
		input logic [31:0] ofs, input logic [4:0] ext);
		logic [31:0] n, m;
		n = a;
		m = area_mask(ext);
		unique case (mode)
			dcu_pkg::STEP_FIXED:  n = a;
			dcu_pkg::STEP_OFFSET: n = a + ofs;
			dcu_pkg::STEP_INC:    n = a + {29'h0, nb};
			dcu_pkg::STEP_DEC:    n = a - {29'h0, nb};
		endcase
		return (a & ~m) | (n & m);
	endfunction : step_addr

	// Largest aligned piece that fits the bytes still owed
	function automatic logic [2:0] piece_of(input logic [1:0] a,
		input logic [2:0] rem);
		return (rem >= 3'd4 && a == 2'b00) ? 3'd4 :
			(rem >= 3'd2 && !a[0]) ? 3'd2 : 3'd1;
	endfunction : piece_of

	function automatic logic [1:0] code_of(input logic [2:0] nb);
		return (nb == 3'd4) ? dcu_pkg::SIZE_LONG :
			(nb == 3'd2) ? dcu_pkg::SIZE_WORD : dcu_pkg::SIZE_BYTE;
	endfunction : code_of

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Bus slave decode: one wait state, effect at the low edge
	wire         cpu_we    = avs_write && !waitreq_reg;
	wire         cpu_rd_go = avs_read && waitreq_reg;
	wire         we_src    = cpu_we && avs_address == dcu_pkg::OFS_SRC;
	wire         we_dst    = cpu_we && avs_address == dcu_pkg::OFS_DST;
	wire         we_cnt    = cpu_we && avs_address == dcu_pkg::OFS_CNT;
	wire         we_ofs    = cpu_we && avs_address == dcu_pkg::OFS_OFFS;
	wire         we_actl   = cpu_we && avs_address == dcu_pkg::OFS_ACTL;
	wire         we_mode   = cpu_we && avs_address == dcu_pkg::OFS_MODE;
	wire         we_blk    = cpu_we && avs_address == dcu_pkg::OFS_BLK;
	wire         we_mode0  = we_mode && avs_byteenable[0];
	wire [31:0]  mode_rd   = {24'h0, cend_reg, esc_reg, err_reg, rpt_reg,
		size_reg, (st_reg != dcu_pkg::DCU_IDLE), dte_reg};

	assign rd_mux =
		(avs_address == dcu_pkg::OFS_SRC)  ? src_reg :
		(avs_address == dcu_pkg::OFS_DST)  ? dst_reg :
		(avs_address == dcu_pkg::OFS_CNT)  ? cnt_reg :
		(avs_address == dcu_pkg::OFS_OFFS) ? ofs_reg :
		(avs_address == dcu_pkg::OFS_ACTL) ? actl_reg :
		(avs_address == dcu_pkg::OFS_MODE) ? mode_rd :
		(avs_address == dcu_pkg::OFS_BLK)  ? {bk_hi_reg, bk_lo_reg} :
		32'h0;

	// Control fields
	wire [1:0] sstep = actl_reg[dcu_pkg::ACTL_SSTEP_LSB +: 2];
	wire [1:0] dstep = actl_reg[dcu_pkg::ACTL_DSTEP_LSB +: 2];
	wire       sarea = actl_reg[dcu_pkg::ACTL_SAREA];
	wire       darea = actl_reg[dcu_pkg::ACTL_DAREA];
	wire       repeat_end_irq_enable = actl_reg[dcu_pkg::ACTL_REPEAT_END_IRQ_ENABLE];
	wire [4:0] sext  = actl_reg[dcu_pkg::ACTL_SEXT_LSB +: 5];
	wire [4:0] dext  = actl_reg[dcu_pkg::ACTL_DEXT_LSB +: 5];

	wire [2:0] unit_bytes = (size_reg == dcu_pkg::SIZE_LONG) ? 3'd4 :
		(size_reg == dcu_pkg::SIZE_WORD) ? 3'd2 : 3'd1;

	// Current piece and its completion
	wire [2:0] cur_piece = piece_of(baddr_reg[1:0], unit_bytes - done_reg);
	wire [2:0] done_sum  = done_reg + cur_piece;
	wire       last_pc   = done_sum == unit_bytes;
	wire       abort     = halt_error || standby;
	wire       go = st_reg == dcu_pkg::DCU_IDLE && dte_reg && xfer_req &&
		!abort;
	wire       rd_ack = st_reg == dcu_pkg::DCU_READ && bus_ack && !abort;
	wire       wr_ack = st_reg == dcu_pkg::DCU_WRITE && bus_ack && !abort;
	wire       unit_end = wr_ack && last_pc;
	wire       blk_end  = rpt_reg && bk_lo_reg <= 16'h1;
	wire [31:0] unit32  = {29'h0, unit_bytes};
	wire       cnt_zero_hit = cnt_reg != 32'h0 && cnt_reg == unit32;
	wire       rpt_stop = unit_end && blk_end && repeat_end_irq_enable;
	wire       cnt_stop = unit_end && cnt_zero_hit;
	wire       resume = we_mode0 && avs_writedata[dcu_pkg::MODE_DTE] &&
		!dte_reg;

	// Read data assembly, one byte lane per step
	wire [31:0] rd_shift = bus_rdata << {done_reg[1:0], 3'b000};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			wire take = rd_ack && done_reg <= 3'(gi) && 3'(gi) < done_sum;
			assign data_next[gi*8 +: 8] = take ? rd_shift[gi*8 +: 8] :
				data_reg[gi*8 +: 8];
		end
	endgenerate

	// Sequencer and transfer-side address updates
	always_comb begin
		logic [31:0] nxt;
		logic [2:0]  pc;
		nxt        = 32'h0;
		pc         = 3'd1;
		st_next    = st_reg;
		done_next  = done_reg;
		breq_next  = breq_reg;
		bwr_next   = bwr_reg;
		baddr_next = baddr_reg;
		bsize_next = bsize_reg;
		src_hw     = src_reg;
		dst_hw     = dst_reg;
		src_hw_upd = 1'b0;
		dst_hw_upd = 1'b0;
		if (abort) begin
			st_next   = dcu_pkg::DCU_IDLE;
			breq_next = 1'b0;
		end else begin
			unique case (st_reg)
				dcu_pkg::DCU_IDLE: begin
					if (go) begin
						pc         = piece_of(src_reg[1:0], unit_bytes);
						st_next    = dcu_pkg::DCU_READ;
						done_next  = 3'd0;
						breq_next  = 1'b1;
						bwr_next   = 1'b0;
						baddr_next = src_reg;
						bsize_next = code_of(pc);
					end
				end
				dcu_pkg::DCU_READ: begin
					if (bus_ack) begin
						src_hw_upd = 1'b1;
						if (last_pc) begin
							src_hw = step_addr(sstep, src_unit_reg,
								unit_bytes, ofs_reg, sext);
							pc         = piece_of(dst_reg[1:0], unit_bytes);
							st_next    = dcu_pkg::DCU_WRITE;
							done_next  = 3'd0;
							bwr_next   = 1'b1;
							baddr_next = dst_reg;
							bsize_next = code_of(pc);
						end else begin
							nxt = step_addr(dcu_pkg::STEP_INC, src_reg,
								cur_piece, ofs_reg, sext);
							pc         = piece_of(nxt[1:0],
								unit_bytes - done_sum);
							src_hw     = nxt;
							done_next  = done_sum;
							baddr_next = nxt;
							bsize_next = code_of(pc);
						end
					end
				end
				dcu_pkg::DCU_WRITE: begin
					if (bus_ack) begin
						dst_hw_upd = 1'b1;
						if (last_pc) begin
							dst_hw = (blk_end && darea) ? dst_start_reg :
								step_addr(dstep, dst_unit_reg, unit_bytes,
									ofs_reg, dext);
							src_hw     = src_start_reg;
							src_hw_upd = blk_end && sarea;
							st_next    = dcu_pkg::DCU_IDLE;
							breq_next  = 1'b0;
						end else begin
							nxt = step_addr(dcu_pkg::STEP_INC, dst_reg,
								cur_piece, ofs_reg, dext);
							pc         = piece_of(nxt[1:0],
								unit_bytes - done_sum);
							dst_hw     = nxt;
							done_next  = done_sum;
							baddr_next = nxt;
							bsize_next = code_of(pc);
						end
					end
				end
				default: begin
					st_next   = dcu_pkg::DCU_IDLE;
					breq_next = 1'b0;
				end
			endcase
		end
	end

	assign src_next = we_src ? merge(src_reg, avs_writedata, avs_byteenable) :
		src_hw_upd ? src_hw : src_reg;
	assign dst_next = we_dst ? merge(dst_reg, avs_writedata, avs_byteenable) :
		dst_hw_upd ? dst_hw : dst_reg;
	assign cnt_next = we_cnt ? merge(cnt_reg, avs_writedata, avs_byteenable) :
		(unit_end && cnt_reg != 32'h0) ? cnt_reg - unit32 : cnt_reg;
	assign ofs_next = we_ofs ? merge(ofs_reg, avs_writedata, avs_byteenable) :
		ofs_reg;
	assign actl_next = we_actl ?
		(merge(actl_reg, avs_writedata, avs_byteenable) &
			dcu_pkg::ACTL_MASK) : actl_reg;
	assign bk_hi_next = (we_blk && avs_byteenable[2] && avs_byteenable[3]) ?
		avs_writedata[31:16] : bk_hi_reg;
	assign bk_lo_next = (we_blk && avs_byteenable[0] && avs_byteenable[1]) ?
		avs_writedata[15:0] :
		(unit_end && rpt_reg) ? (blk_end ? bk_hi_reg : bk_lo_reg - 16'h1) :
		bk_lo_reg;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			src_reg  <= dcu_pkg::RST_WORD;
			dst_reg  <= dcu_pkg::RST_WORD;
			cnt_reg  <= dcu_pkg::RST_WORD;
			ofs_reg  <= dcu_pkg::RST_WORD;
			actl_reg <= dcu_pkg::RST_WORD;
			data_reg <= dcu_pkg::RST_WORD;
		end else begin
			src_reg  <= src_next;
			dst_reg  <= dst_next;
			cnt_reg  <= cnt_next;
			ofs_reg  <= ofs_next;
			actl_reg <= actl_next;
			data_reg <= data_next;
		end
	end

	// Start addresses follow software writes; unit starts follow the bus
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			src_start_reg <= dcu_pkg::RST_WORD;
			dst_start_reg <= dcu_pkg::RST_WORD;
			src_unit_reg  <= dcu_pkg::RST_WORD;
			dst_unit_reg  <= dcu_pkg::RST_WORD;
			bk_hi_reg     <= dcu_pkg::RST_HALF;
			bk_lo_reg     <= dcu_pkg::RST_HALF;
		end else begin
			src_start_reg <= we_src ? src_next : src_start_reg;
			dst_start_reg <= we_dst ? dst_next : dst_start_reg;
			src_unit_reg  <= go ? src_reg : src_unit_reg;
			dst_unit_reg  <= (rd_ack && last_pc) ? dst_reg : dst_unit_reg;
			bk_hi_reg     <= bk_hi_next;
			bk_lo_reg     <= bk_lo_next;
		end
	end

	// Mode bits; hardware sets win over software clears
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dte_reg  <= 1'b0;
			size_reg <= dcu_pkg::SIZE_BYTE;
			rpt_reg  <= 1'b0;
			err_reg  <= 1'b0;
			esc_reg  <= 1'b0;
			cend_reg <= 1'b0;
		end else begin
			dte_reg <= (abort || rpt_stop || cnt_stop) ? 1'b0 :
				we_mode0 ? avs_writedata[dcu_pkg::MODE_DTE] : dte_reg;
			size_reg <= we_mode0 ?
				avs_writedata[dcu_pkg::MODE_SIZE_LSB +: 2] : size_reg;
			rpt_reg <= we_mode0 ? avs_writedata[dcu_pkg::MODE_RPT] : rpt_reg;
			err_reg <= halt_error ||
				(err_reg && !(we_mode0 && !avs_writedata[dcu_pkg::MODE_ERR]));
			esc_reg <= rpt_stop || (esc_reg && !resume &&
				!(we_mode0 && !avs_writedata[dcu_pkg::MODE_ESC]));
			cend_reg <= cnt_stop || (cend_reg && !resume &&
				!(we_mode0 && !avs_writedata[dcu_pkg::MODE_CEND]));
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_reg        <= dcu_pkg::DCU_IDLE;
			done_reg      <= 3'd0;
			breq_reg      <= 1'b0;
			bwr_reg       <= 1'b0;
			baddr_reg     <= dcu_pkg::RST_WORD;
			bsize_reg     <= dcu_pkg::SIZE_BYTE;
			unit_done_reg <= 1'b0;
			wdata_reg     <= dcu_pkg::RST_WORD;
			waitreq_reg   <= 1'b1;
			rdata_reg     <= dcu_pkg::RST_WORD;
		end else begin
			st_reg        <= st_next;
			done_reg      <= done_next;
			breq_reg      <= breq_next;
			bwr_reg       <= bwr_next;
			baddr_reg     <= baddr_next;
			bsize_reg     <= bsize_next;
			unit_done_reg <= unit_end;
			// Write pieces take consumed lanes off the bottom
			wdata_reg     <= data_next >> {done_next[1:0], 3'b000};
			waitreq_reg   <= !((avs_read || avs_write) && waitreq_reg);
			rdata_reg     <= cpu_rd_go ? rd_mux : rdata_reg;
		end
	end

	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = waitreq_reg;
	assign bus_req         = breq_reg;
	assign bus_write       = bwr_reg;
	assign bus_addr        = baddr_reg;
	assign bus_size        = bsize_reg;
	assign bus_wdata       = wdata_reg;
	assign unit_done       = unit_done_reg;

endmodule : dcu_channel

// [tb/dcu_mem_model.sv]
// External memory model answering one bus piece per bus_ack.
// Assumes pieces hold until acknowledged; slow adds three wait states.
`timescale 1ns/1ps
module dcu_mem_model (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        bus_req,
	input  wire logic [31:0] bus_addr,
	input  wire logic        slow,
	output logic      [31:0] bus_rdata,
	output logic             bus_ack
);
	logic [1:0]  wait_reg;
	logic [31:0] last_reg;
	wire  logic  ack_now;

	assign ack_now = bus_req && !bus_ack && wait_reg == {slow, slow};
	// Off the ack cycle the lines show the inverse, never stale data
	assign bus_rdata = bus_ack ? last_reg : ~last_reg;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			wait_reg <= 2'h0;
			bus_ack  <= 1'b0;
			last_reg <= 32'h0;
		end else begin
			bus_ack  <= ack_now;
			wait_reg <= (bus_req && !bus_ack && !ack_now) ? wait_reg + 2'h1 : 2'h0;
			if (ack_now)
				last_reg <= bus_addr ^ 32'h5a5a5a5a;
		end
	end
endmodule : dcu_mem_model

// [tb/dcu_channel_chk.sv]
// Port checker for the DMA channel.
// Assumes one clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module dcu_channel_chk (
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        halt_error,
	input wire logic        standby,
	input wire logic        bus_req,
	input wire logic        bus_write,
	input wire logic [31:0] bus_addr,
	input wire logic [1:0]  bus_size,
	input wire logic        bus_ack,
	input wire logic        unit_done
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	property p_wait_one;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("waitrequest stayed high");
	property p_wait_pulse;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_wait_pulse: assert property (p_wait_pulse)
		else $error("waitrequest low twice");
	property p_hold;
		bus_req && !bus_ack && !halt_error && !standby |=> bus_req &&
			$stable(bus_addr) && $stable(bus_size) && $stable(bus_write);
	endproperty
	a_hold: assert property (p_hold)
		else $error("bus piece changed before ack");
	property p_ralign;
		bus_req && !bus_write |-> bus_size != 2'h3 &&
			(bus_size != 2'h1 || !bus_addr[0]) &&
			(bus_size != 2'h2 || bus_addr[1:0] == 2'h0);
	endproperty
	a_ralign: assert property (p_ralign)
		else $error("misaligned read piece");
	property p_walign;
		bus_req && bus_write |-> bus_size != 2'h3 &&
			(bus_size != 2'h1 || !bus_addr[0]) &&
			(bus_size != 2'h2 || bus_addr[1:0] == 2'h0);
	endproperty
	a_walign: assert property (p_walign)
		else $error("misaligned write piece");
	property p_split;
		(bus_req && !bus_write && bus_ack) ##1 (bus_req && !bus_write) |->
			bus_addr == $past(bus_addr) + (32'h1 << $past(bus_size));
	endproperty
	a_split: assert property (p_split)
		else $error("split read step wrong");
	property p_abort;
		halt_error || standby |=> !bus_req;
	endproperty
	a_abort: assert property (p_abort)
		else $error("bus request kept after abort");
	property p_order;
		bus_req && bus_write && bus_ack |=> !(bus_req && !bus_write);
	endproperty
	a_order: assert property (p_order)
		else $error("read piece right after write");
	property p_done;
		unit_done |-> $past(bus_req && bus_write && bus_ack);
	endproperty
	a_done: assert property (p_done)
		else $error("unit end without write ack");
endmodule : dcu_channel_chk

bind dcu_channel dcu_channel_chk dcu_channel_chk_i (.mclk(mclk),
	.resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .halt_error(halt_error),
	.standby(standby), .bus_req(bus_req), .bus_write(bus_write),
	.bus_addr(bus_addr), .bus_size(bus_size), .bus_ack(bus_ack),
	.unit_done(unit_done));

// [tb/tb.sv]
// Testbench: register accesses and single units through the channel.
// Assumes the memory model answers every bus piece.
`timescale 1ns/1ps
module tb;
	logic        mclk, resetn, avs_read, avs_write, avs_waitrequest;
	logic        xfer_req, halt_error, standby, slow;
	logic        bus_req, bus_write, bus_ack, unit_done;
	logic [4:0]  avs_address;
	logic [3:0]  avs_byteenable;
	logic [1:0]  bus_size;
	logic [31:0] avs_writedata, avs_readdata, bus_addr, bus_wdata;
	logic [31:0] bus_rdata, q, wd_seen;
	logic [31:0] ex [4];
	int          bad_count, cmp_count;

	dcu_channel dcu_channel_i (.mclk(mclk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .xfer_req(xfer_req),
		.halt_error(halt_error), .standby(standby), .bus_req(bus_req),
		.bus_write(bus_write), .bus_addr(bus_addr), .bus_size(bus_size),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
		.unit_done(unit_done));
	dcu_mem_model dcu_mem_model_i (.mclk(mclk), .resetn(resetn),
		.bus_req(bus_req), .bus_addr(bus_addr), .slow(slow),
		.bus_rdata(bus_rdata), .bus_ack(bus_ack));

	// Last write data taken by the memory side
	always @(posedge mclk) begin
		if (bus_req && bus_write && bus_ack) begin
			wd_seen <= bus_wdata;
		end
	end

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task end_sim;
		if (bad_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] s, input logic [31:0] e, input string n);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task tmo(input int n, input string w);
		if (n >= 200) begin
			bad_count++;
			$display("[FAIL] %s expected answer seen timeout", w);
			end_sim();
		end
	endtask : tmo

	// Avalon access: hold everything until waitrequest is sampled low
	task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= !w;
		avs_write     <= w;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 200);
		tmo(n, "waitrequest");
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : acc

	task rd(input logic [4:0] a, input logic [31:0] e, input string n);
		acc(1'b0, a, 32'h0);
		chk(q, e, n);
	endtask : rd

	task cfg(input logic [31:0] s, d, c, o, a, m);
		acc(1'b1, dcu_pkg::OFS_MODE, 32'h0);
		acc(1'b1, dcu_pkg::OFS_SRC, s);
		acc(1'b1, dcu_pkg::OFS_DST, d);
		acc(1'b1, dcu_pkg::OFS_CNT, c);
		acc(1'b1, dcu_pkg::OFS_OFFS, o);
		acc(1'b1, dcu_pkg::OFS_ACTL, a);
		acc(1'b1, dcu_pkg::OFS_MODE, m);
	endtask : cfg

	task start;
		int n;
		@(posedge mclk);
		xfer_req <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (bus_req !== 1'b1 && n < 200);
		tmo(n, "bus_req");
		xfer_req <= 1'b0;
	endtask : start

	task go;
		int n;
		start();
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (unit_done !== 1'b1 && n < 200);
		tmo(n, "unit_done");
	endtask : go

	initial begin
		bad_count = 0;
		cmp_count = 0;
		resetn = 1'b0;
		{avs_read, avs_write, xfer_req, halt_error, standby, slow} = 6'h0;
		avs_address = 5'h0;
		avs_byteenable = 4'hf;
		avs_writedata = 32'h0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		rd(dcu_pkg::OFS_SRC, 32'h0, "source reset");
		rd(dcu_pkg::OFS_CNT, 32'h0, "count reset");
		rd(5'h1c, 32'h0, "unmapped");
		ex = '{32'h100, 32'h110, 32'h104, 32'hfc};
		for (int i = 0; i < 4; i++) begin
			slow <= i[0];
			cfg(32'h100, 32'h200, 32'h8, 32'h10, {28'h0, i[1:0], i[1:0]}, 32'h9);
			go();
			chk(wd_seen, 32'h100 ^ 32'h5a5a5a5a, "write data");
			rd(dcu_pkg::OFS_SRC, ex[i], "source step");
			rd(dcu_pkg::OFS_DST, ex[i] + 32'h100, "dest step");
			rd(dcu_pkg::OFS_CNT, 32'h4, "count long");
		end
		for (int i = 0; i < 3; i++) begin
			cfg(32'h100, 32'h200, 32'h10, 32'h0, 32'ha, {28'h0, i[1:0], 2'h1});
			go();
			rd(dcu_pkg::OFS_SRC, 32'h100 + (32'h1 << i), "size step");
			rd(dcu_pkg::OFS_CNT, 32'h10 - (32'h1 << i), "size count");
		end
		cfg(32'h102, 32'h201, 32'h8, 32'h0, 32'ha, 32'h9);
		go();
		chk(wd_seen, 32'h5b, "split write data");
		rd(dcu_pkg::OFS_SRC, 32'h106, "split source");
		rd(dcu_pkg::OFS_DST, 32'h205, "split dest");
		cfg(32'h8, 32'h200, 32'h0, 32'hfffffff0, 32'h1, 32'h1);
		go();
		rd(dcu_pkg::OFS_SRC, 32'hfffffff8, "offset wrap");
		rd(dcu_pkg::OFS_CNT, 32'h0, "zero count");
		cfg(32'h10c, 32'h200, 32'h4, 32'h0, 32'h402, 32'h9);
		go();
		rd(dcu_pkg::OFS_SRC, 32'h100, "extended area");
		rd(dcu_pkg::OFS_CNT, 32'h0, "count to zero");
		rd(dcu_pkg::OFS_MODE, 32'h88, "count end");
		acc(1'b1, dcu_pkg::OFS_MODE, 32'h0);
		acc(1'b1, dcu_pkg::OFS_BLK, 32'h00010001);
		cfg(32'h300, 32'h200, 32'h10, 32'h0, 32'h7a, 32'h11);
		go();
		rd(dcu_pkg::OFS_SRC, 32'h300, "repeat restore");
		rd(dcu_pkg::OFS_DST, 32'h200, "repeat dest");
		rd(dcu_pkg::OFS_MODE, 32'h50, "repeat suspend");
		acc(1'b1, dcu_pkg::OFS_MODE, 32'h51);
		rd(dcu_pkg::OFS_MODE, 32'h11, "escape cleared");
		go();
		rd(dcu_pkg::OFS_SRC, 32'h300, "resumed source");
		rd(dcu_pkg::OFS_CNT, 32'he, "resumed count");
		cfg(32'h100, 32'h200, 32'h8, 32'h0, 32'ha, 32'h9);
		start();
		halt_error <= 1'b1;
		@(posedge mclk);
		halt_error <= 1'b0;
		rd(dcu_pkg::OFS_MODE, 32'h28, "halt mode");
		cfg(32'h100, 32'h200, 32'h8, 32'h0, 32'ha, 32'h9);
		start();
		standby <= 1'b1;
		@(posedge mclk);
		standby <= 1'b0;
		rd(dcu_pkg::OFS_MODE, 32'h8, "standby mode");
		end_sim();
	end
endmodule : tb
